/* rtl/epm_pkg.sv */
// Package for the extended page 1 media control register bank.
// Assumes an APB slave with 32-bit data; register offsets are word indices.
package epm_pkg;

  // Page select values
  localparam logic [15:0] PAGE_MAIN  = 16'h0000;
  localparam logic [15:0] PAGE_EXT1  = 16'h0001;

  // Register indices (byte address is four times the index)
  localparam logic [4:0] IDX_UPPER_LO = 5'h10;
  localparam logic [4:0] IDX_SMC      = 5'h10;
  localparam logic [4:0] IDX_CRC      = 5'h12;
  localparam logic [4:0] IDX_EMC      = 5'h13;
  localparam logic [4:0] IDX_PAGE     = 5'h1f;
  // Own registers beyond the PHY map (word indices 32 and up)
  localparam logic [5:0] IDX_IRQ_STAT = 6'h20;
  localparam logic [5:0] IDX_IRQ_EN   = 6'h21;
  localparam logic [5:0] IDX_IRQ_CLR  = 6'h22;
  localparam logic [5:0] IDX_CTRL     = 6'h23;

  // Field positions
  localparam int SMC_TXRF_LSB  = 14;
  localparam int SMC_LPRF_LSB  = 12;
  localparam int SMC_ALLOW_1GX = 9;
  localparam int SMC_ALLOW_FX  = 8;
  localparam int SMC_FEF       = 6;
  localparam int CRC_SEEN      = 15;
  localparam int EMC_LED_LSB   = 12;
  localparam int EMC_BLINK     = 11;
  localparam int EMC_FLF       = 4;
  localparam int EMC_MDIX_LSB  = 2;
  localparam int EMC_SDPOL     = 0;

  // Writable masks and reset values
  localparam logic [15:0] SMC_WMASK = 16'hc300;
  localparam logic [15:0] SMC_RST   = 16'h0300;
  localparam logic [15:0] EMC_WMASK = 16'hf81d;
  localparam logic [15:0] EMC_RST   = 16'h0000;
  localparam logic [15:0] SMC_STICKY = 16'h0300;

  // Counter wrap point
  localparam logic [13:0] CRC_MAX = 14'd9999;

  // Interrupt bits
  localparam int IRQ_FEF  = 0;
  localparam int IRQ_PKT  = 1;
  localparam int IRQ_WRAP = 2;
  localparam int IRQ_W    = 3;

endpackage

/* rtl/epm_regs.sv */
// Extended page 1 register bank: media control, CRC good counter, mode control.
// Assumes APB master on mclk, media events as single-cycle pulses in mclk domain.
`timescale 1ns/1ps

module epm_regs (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Port identity and soft reset
  input  wire logic [1:0]  port_id,
  input  wire logic        soft_reset,
  // Media status inputs
  input  wire logic [1:0]  link_partner_rf,
  input  wire logic        fef_event,
  input  wire logic        crc_good_pkt,
  input  wire logic        signal_detect_input,
  // Media control outputs
  output logic      [1:0]  tx_remote_fault,
  output logic             allow_1000x,
  output logic             allow_100fx,
  output logic      [3:0]  led_ext_mode,
  output logic             led_blink_after_hold,
  output logic             fast_link_fail_en,
  output logic      [1:0]  mdix_mode,
  output logic             signal_detect,
  output logic             page1_active,
  // Interrupt
  output logic             irq
);

  // Register state
  logic [15:0]             page_r;        // Page select
  logic [1:0]              txrf_r;        // Transmit remote fault
  logic [1:0]              lprf_r;        // Received remote fault
  logic                    al1g_r;        // Sticky 1000BASE-X allow
  logic                    alfx_r;        // Sticky 100BASE-FX allow
  logic                    fef_r;         // Far end fault flag
  logic                    seen_r;        // Packet since last read
  logic [13:0]             cnt_r;         // Good CRC count
  logic [15:0]             emc_r;         // Mode control
  logic [epm_pkg::IRQ_W-1:0] ist_r;       // Sticky interrupt status
  logic [epm_pkg::IRQ_W-1:0] ien_r;       // Interrupt enable
  logic [15:0]             smc_v;         // Assembled media control word
  logic [15:0]             crc_v;         // Assembled counter word
  logic [15:0]             rd_v;          // Read mux output
  logic                    hit_v;         // Address decodes
  logic                    acc;           // Access phase
  logic                    wr;            // Write strobe
  logic                    rd;            // Read strobe
  logic                    rd_smc;        // Read of media control
  logic                    rd_crc;        // Read of counter
  logic                    wrap_v;        // Counter wraps this cycle

  // Word index decode from byte address
  function automatic logic [5:0] widx(input logic [7:0] a);
    widx = a[7:2];
  endfunction

  // Extended slot is live only with page 1 and the word index of that slot
  function automatic logic ext_hit(input logic [5:0] i, input logic [4:0] r,
                                   input logic [15:0] pg);
    ext_hit = (pg == epm_pkg::PAGE_EXT1) && (i == {1'b0, r});
  endfunction

  // Single-cycle access; APB answers in the first access cycle
  assign acc    = psel && penable;
  assign wr     = acc && pwrite;
  assign rd     = acc && !pwrite;
  assign rd_smc = rd && ext_hit(widx(paddr), epm_pkg::IDX_SMC, page_r);
  assign rd_crc = rd && ext_hit(widx(paddr), epm_pkg::IDX_CRC, page_r);
  assign wrap_v = crc_good_pkt && (cnt_r == epm_pkg::CRC_MAX);

  // Assembled views, reserved bits zero
  always_comb begin
    smc_v = 16'h0000;
    smc_v[epm_pkg::SMC_TXRF_LSB +: 2] = txrf_r;
    smc_v[epm_pkg::SMC_LPRF_LSB +: 2] = lprf_r;
    smc_v[epm_pkg::SMC_ALLOW_1GX]     = al1g_r;
    smc_v[epm_pkg::SMC_ALLOW_FX]      = alfx_r;
    smc_v[epm_pkg::SMC_FEF]           = fef_r;
    crc_v = {seen_r, 1'b0, cnt_r};
  end

  // Read mux; unmapped and main-page upper slots read zero
  always_comb begin
    rd_v  = 16'h0000;
    hit_v = 1'b1;
    if (widx(paddr) == {1'b0, epm_pkg::IDX_PAGE}) begin
      rd_v = page_r;
    end else if (ext_hit(widx(paddr), epm_pkg::IDX_SMC, page_r)) begin
      rd_v = smc_v;
    end else if (ext_hit(widx(paddr), epm_pkg::IDX_CRC, page_r)) begin
      rd_v = crc_v;
    end else if (ext_hit(widx(paddr), epm_pkg::IDX_EMC, page_r)) begin
      rd_v = emc_r;
    end else if (widx(paddr) == epm_pkg::IDX_IRQ_STAT) begin
      rd_v = {13'h0000, ist_r};
    end else if (widx(paddr) == epm_pkg::IDX_IRQ_EN) begin
      rd_v = {13'h0000, ien_r};
    end else if (widx(paddr) == epm_pkg::IDX_IRQ_CLR) begin
      rd_v = 16'h0000;
    end else if (widx(paddr) < {1'b0, epm_pkg::IDX_UPPER_LO}) begin
      rd_v = 16'h0000;
    end else if (widx(paddr) < {1'b0, epm_pkg::IDX_PAGE}) begin
      rd_v = 16'h0000;
    end else begin
      hit_v = 1'b0;
    end
  end

  // APB answer: ready in access phase, error on unmapped word
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !hit_v;
      prdata  <= (psel && !penable && !pwrite) ? {16'h0000, rd_v} : 32'h0000_0000;
    end
  end

  // Page select register; any value is stored, only 0x0001 opens page 1
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      page_r <= epm_pkg::PAGE_MAIN;
    end else if (wr && pready && widx(paddr) == {1'b0, epm_pkg::IDX_PAGE}) begin
      page_r <= pwdata[15:0];
    end
  end

  // Media control writable and sticky fields
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      txrf_r <= 2'h0;
      al1g_r <= epm_pkg::SMC_RST[epm_pkg::SMC_ALLOW_1GX];
      alfx_r <= epm_pkg::SMC_RST[epm_pkg::SMC_ALLOW_FX];
    end else if (soft_reset) begin
      txrf_r <= 2'h0;
    end else if (wr && pready && ext_hit(widx(paddr), epm_pkg::IDX_SMC, page_r)) begin
      txrf_r <= pwdata[epm_pkg::SMC_TXRF_LSB +: 2];
      al1g_r <= pwdata[epm_pkg::SMC_ALLOW_1GX];
      alfx_r <= pwdata[epm_pkg::SMC_ALLOW_FX];
    end
  end

  // Received remote fault follows the link partner
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      lprf_r <= 2'h0;
    end else begin
      lprf_r <= link_partner_rf;
    end
  end

  // Far end fault; a new event wins over the read clear
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      fef_r <= 1'b0;
    end else if (fef_event) begin
      fef_r <= 1'b1;
    end else if (rd_smc && pready) begin
      fef_r <= 1'b0;
    end
  end

  // Good CRC counter; a packet in the read cycle restarts at one
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cnt_r  <= 14'h0000;
      seen_r <= 1'b0;
    end else if (rd_crc && pready) begin
      cnt_r  <= crc_good_pkt ? 14'h0001 : 14'h0000;
      seen_r <= crc_good_pkt;
    end else if (crc_good_pkt) begin
      cnt_r  <= wrap_v ? 14'h0000 : cnt_r + 14'h0001;
      seen_r <= 1'b1;
    end
  end

  // Mode control; fast link fail taken only on port 0
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      emc_r <= epm_pkg::EMC_RST;
    end else if (soft_reset) begin
      emc_r <= epm_pkg::EMC_RST;
    end else if (wr && pready && ext_hit(widx(paddr), epm_pkg::IDX_EMC, page_r)) begin
      emc_r <= pwdata[15:0] & epm_pkg::EMC_WMASK;
      if (port_id != 2'h0) begin
        emc_r[epm_pkg::EMC_FLF] <= emc_r[epm_pkg::EMC_FLF];
      end
    end
  end

  // Interrupt enable and sticky status; set beats clear
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ien_r <= 3'h0;
      ist_r <= 3'h0;
    end else begin
      if (wr && pready && widx(paddr) == epm_pkg::IDX_IRQ_EN) begin
        ien_r <= pwdata[epm_pkg::IRQ_W-1:0];
      end
      ist_r <= (ist_r & ~((wr && pready && widx(paddr) == epm_pkg::IDX_IRQ_CLR)
                          ? pwdata[epm_pkg::IRQ_W-1:0] : 3'h0))
               | {wrap_v, crc_good_pkt, fef_event};
    end
  end

  // Registered outputs toward media and LED logic
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      tx_remote_fault      <= 2'h0;
      allow_1000x          <= 1'b0;
      allow_100fx          <= 1'b0;
      led_ext_mode         <= 4'h0;
      led_blink_after_hold <= 1'b0;
      fast_link_fail_en    <= 1'b0;
      mdix_mode            <= 2'h0;
      signal_detect        <= 1'b0;
      page1_active         <= 1'b0;
      irq                  <= 1'b0;
    end else begin
      tx_remote_fault      <= txrf_r;
      allow_1000x          <= al1g_r;
      allow_100fx          <= alfx_r;
      led_ext_mode         <= emc_r[epm_pkg::EMC_LED_LSB +: 4];
      led_blink_after_hold <= emc_r[epm_pkg::EMC_BLINK];
      fast_link_fail_en    <= emc_r[epm_pkg::EMC_FLF];
      mdix_mode            <= emc_r[epm_pkg::EMC_MDIX_LSB +: 2];
      signal_detect        <= signal_detect_input ^ emc_r[epm_pkg::EMC_SDPOL];
      page1_active         <= (page_r == epm_pkg::PAGE_EXT1);
      irq                  <= |(ist_r & ien_r);
    end
  end

  // Checks
  property p_fef_read_clear;
    @(posedge mclk) disable iff (!rst_n)
    (rd_smc && pready && !fef_event) |=> !fef_r;
  endproperty
  a_fef_read_clear: assert property (p_fef_read_clear) else $error("fault flag kept");
  property p_fef_set;
    @(posedge mclk) disable iff (!rst_n) fef_event |=> fef_r;
  endproperty
  a_fef_set: assert property (p_fef_set) else $error("fault flag lost");
  property p_cnt_wrap;
    @(posedge mclk) disable iff (!rst_n)
    (crc_good_pkt && !(rd_crc && pready) && cnt_r == epm_pkg::CRC_MAX) |=> cnt_r == 14'h0000;
  endproperty
  a_cnt_wrap: assert property (p_cnt_wrap) else $error("counter wrap wrong");
  property p_cnt_range;
    @(posedge mclk) disable iff (!rst_n) cnt_r <= epm_pkg::CRC_MAX;
  endproperty
  a_cnt_range: assert property (p_cnt_range) else $error("counter out of range");
  property p_seen;
    @(posedge mclk) disable iff (!rst_n) crc_good_pkt |=> seen_r;
  endproperty
  a_seen: assert property (p_seen) else $error("packet flag lost");
  property p_page_sel;
    @(posedge mclk) disable iff (!rst_n)
    (wr && pready && widx(paddr) == 6'h1f && pwdata[15:0] == 16'h0001) |=> ##1 page1_active;
  endproperty
  a_page_sel: assert property (p_page_sel) else $error("page 1 not selected");
  property p_page_main;
    @(posedge mclk) disable iff (!rst_n)
    (wr && pready && widx(paddr) == 6'h1f && pwdata[15:0] == 16'h0000) |=> ##1 !page1_active;
  endproperty
  a_page_main: assert property (p_page_main) else $error("main page not restored");
  property p_flf_port0;
    @(posedge mclk) disable iff (!rst_n)
    (port_id != 2'h0 && !soft_reset) |=> $stable(emc_r[4]);
  endproperty
  a_flf_port0: assert property (p_flf_port0) else $error("fast fail set off port 0");
  property p_sdpol;
    @(posedge mclk) disable iff (!rst_n)
    ##1 signal_detect == ($past(signal_detect_input) ^ $past(emc_r[0]));
  endproperty
  a_sdpol: assert property (p_sdpol) else $error("signal detect polarity");
  c_wrap: cover property (@(posedge mclk) disable iff (!rst_n) wrap_v);
  c_fef_clear: cover property (@(posedge mclk) disable iff (!rst_n) rd_smc && pready && fef_r);
  c_irq: cover property (@(posedge mclk) disable iff (!rst_n) irq);
  c_soft: cover property (@(posedge mclk) disable iff (!rst_n) soft_reset && al1g_r);

  // Counter read without a packet leaves an empty, unflagged counter
  property p_cnt_read_clear;
    @(posedge mclk) disable iff (!rst_n)
    (rd_crc && pready && !crc_good_pkt) |=> (cnt_r == 14'h0000 && !seen_r);
  endproperty
  a_cnt_read_clear: assert property (p_cnt_read_clear) else $error("counter not cleared");

  // Each good packet below the wrap point adds exactly one
  property p_cnt_step;
    @(posedge mclk) disable iff (!rst_n)
    (crc_good_pkt && !(rd_crc && pready) && cnt_r != epm_pkg::CRC_MAX)
      |=> cnt_r == $past(cnt_r) + 14'h0001;
  endproperty
  a_cnt_step: assert property (p_cnt_step) else $error("counter step wrong");

  // Soft reset must not touch the sticky allow bits
  property p_sticky_soft;
    @(posedge mclk) disable iff (!rst_n)
    soft_reset |=> ($stable(al1g_r) && $stable(alfx_r));
  endproperty
  a_sticky_soft: assert property (p_sticky_soft) else $error("sticky bit lost");

  // Soft reset returns the non-sticky fields to their defaults
  property p_soft_clear;
    @(posedge mclk) disable iff (!rst_n)
    soft_reset |=> (txrf_r == 2'h0 && emc_r == epm_pkg::EMC_RST);
  endproperty
  a_soft_clear: assert property (p_soft_clear) else $error("soft reset missed");

  // Reserved mode control bits never hold a one
  property p_emc_reserved;
    @(posedge mclk) disable iff (!rst_n)
    (emc_r & ~epm_pkg::EMC_WMASK) == 16'h0000;
  endproperty
  a_emc_reserved: assert property (p_emc_reserved) else $error("reserved bit set");

  // Upper slots on the main page read back zero
  property p_main_upper_zero;
    @(posedge mclk) disable iff (!rst_n)
    (psel && !penable && !pwrite && page_r != epm_pkg::PAGE_EXT1
     && widx(paddr) >= {1'b0, epm_pkg::IDX_UPPER_LO}
     && widx(paddr) < {1'b0, epm_pkg::IDX_PAGE}) |=> prdata == 32'h0000_0000;
  endproperty
  a_main_upper_zero: assert property (p_main_upper_zero) else $error("main slot not zero");

  // Level interrupt trails enabled status by one cycle
  property p_irq_level;
    @(posedge mclk) disable iff (!rst_n)
    ##1 irq == $past(|(ist_r & ien_r));
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt level wrong");

  // Received remote fault tracks the link partner input
  property p_lprf;
    @(posedge mclk) disable iff (!rst_n)
    ##1 lprf_r == $past(link_partner_rf);
  endproperty
  a_lprf: assert property (p_lprf) else $error("remote fault not tracked");

  // Transmitted remote fault pin follows its field
  property p_txrf_out;
    @(posedge mclk) disable iff (!rst_n)
    ##1 tx_remote_fault == $past(txrf_r);
  endproperty
  a_txrf_out: assert property (p_txrf_out) else $error("remote fault pin wrong");

endmodule // epm_regs

/* test/epm_mgmt.sv */
// Station management model: an APB master for the page 1 register bank.
// Assumes mclk is free running and the slave answers with a pready pulse.
`timescale 1ns/1ps
module epm_mgmt (
  // Clock
  input  wire logic        mclk,
  // APB master side
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [7:0]  paddr,
  output logic      [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  logic err;  // Error flag of the last transfer

  // Idle bus at start; data carries a pattern, not a stale value
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h5a5a_a5a5;
    err     = 1'b0;
  end

  // One APB transfer; page writes of 0x0001 or 0x0000 steer the window
  task automatic xfer(input logic w, input logic [5:0] idx, input logic [15:0] d,
                      output logic [31:0] q);
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {idx, 2'b00};
    pwdata  <= {16'h0000, d};
    @(posedge mclk);
    penable <= 1'b1;
    // Hold everything until pready is seen high at an edge
    do @(posedge mclk); while (pready !== 1'b1);
    q   = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    pwdata  <= ~pwdata;  // Released data must not look valid
  endtask
endmodule // epm_mgmt

/* test/tb.sv */
// Self-checking bench for the page 1 register bank.
// Assumes the management model drives APB and the bench drives media inputs.
`timescale 1ns/1ps
module tb;
  logic        mclk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic [1:0]  port_id, link_partner_rf, tx_remote_fault, mdix_mode;
  logic        soft_reset, fef_event, crc_good_pkt, signal_detect_input;
  logic        allow_1000x, allow_100fx, led_blink_after_hold, fast_link_fail_en;
  logic        signal_detect, page1_active, irq;
  logic [3:0]  led_ext_mode;
  int          failures, comparisons, cycles;

  // Clock at 40 MHz
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  epm_mgmt u_mgmt (.mclk(mclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  epm_regs u_dut (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .port_id(port_id), .soft_reset(soft_reset),
    .link_partner_rf(link_partner_rf), .fef_event(fef_event), .crc_good_pkt(crc_good_pkt),
    .signal_detect_input(signal_detect_input), .tx_remote_fault(tx_remote_fault),
    .allow_1000x(allow_1000x), .allow_100fx(allow_100fx), .led_ext_mode(led_ext_mode),
    .led_blink_after_hold(led_blink_after_hold), .fast_link_fail_en(fast_link_fail_en),
    .mdix_mode(mdix_mode), .signal_detect(signal_detect), .page1_active(page1_active),
    .irq(irq));

  // Verdict and end of run
  task automatic final_report;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Single compare point
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Register access helpers
  task automatic wr(input logic [5:0] idx, input logic [15:0] d);
    u_mgmt.xfer(1'b1, idx, d, q);
  endtask
  task automatic rd(input logic [5:0] idx, input logic [15:0] exp);
    u_mgmt.xfer(1'b0, idx, 16'h0000, q);
    check(q, {16'h0000, exp});
  endtask
  // Outputs trail the register state by one cycle; stay on the edge
  task automatic settle;
    repeat (2) @(posedge mclk);
  endtask
  // Back-to-back packet pulses
  task automatic packets(input int n);
    repeat (n) begin
      crc_good_pkt <= 1'b1;
      @(posedge mclk);
    end
    crc_good_pkt <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask

  // Hang guard, sized well above the 10k-packet wrap test
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      final_report();
    end
  end

  // Main sequence
  initial begin
    failures = 0; comparisons = 0; cycles = 0;
    rst_n = 1'b0; port_id = 2'd0; soft_reset = 1'b0; link_partner_rf = 2'b00;
    fef_event = 1'b0; crc_good_pkt = 1'b0; signal_detect_input = 1'b0;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    rd(epm_pkg::IDX_SMC, 16'h0000);
    wr(epm_pkg::IDX_PAGE, epm_pkg::PAGE_EXT1);
    rd(epm_pkg::IDX_SMC, 16'h0300);
    settle();
    check(page1_active, 1'b1);
    link_partner_rf <= 2'b10;
    wr(epm_pkg::IDX_SMC, 16'hffff);
    rd(epm_pkg::IDX_SMC, 16'he300);
    settle();
    check(tx_remote_fault, 2'b11);
    rd(6'h11, 16'h0000);
    // Far-end fault with interrupt, then clear
    wr(epm_pkg::IDX_IRQ_EN, 16'h0007);
    fef_event <= 1'b1;
    @(posedge mclk);
    fef_event <= 1'b0;
    settle();
    check(irq, 1'b1);
    rd(epm_pkg::IDX_SMC, 16'he340);
    rd(epm_pkg::IDX_SMC, 16'he300);
    rd(epm_pkg::IDX_IRQ_STAT, 16'h0001);
    wr(epm_pkg::IDX_IRQ_CLR, 16'h0007);
    settle();
    check(irq, 1'b0);
    // Good packet counter, then a full wrap
    packets(3);
    rd(epm_pkg::IDX_CRC, 16'h8003);
    rd(epm_pkg::IDX_CRC, 16'h0000);
    packets(10000);
    rd(epm_pkg::IDX_CRC, 16'h8000);
    rd(epm_pkg::IDX_IRQ_STAT, 16'h0006);
    // Mode control; fast link fail only from port 0
    port_id <= 2'd1;
    wr(epm_pkg::IDX_EMC, 16'hffff);
    rd(epm_pkg::IDX_EMC, 16'hf80d);
    port_id <= 2'd0;
    wr(epm_pkg::IDX_EMC, 16'hffff);
    rd(epm_pkg::IDX_EMC, 16'hf81d);
    settle();
    check({led_ext_mode, led_blink_after_hold, fast_link_fail_en}, 6'h3f);
    check(signal_detect, 1'b1);
    for (int m = 0; m < 4; m++) begin
      wr(epm_pkg::IDX_EMC, {12'h000, m[1:0], 2'b00});
      settle();
      check(mdix_mode, m[1:0]);
    end
    // Soft reset keeps sticky allow bits
    wr(epm_pkg::IDX_SMC, 16'hc000);
    soft_reset <= 1'b1;
    @(posedge mclk);
    soft_reset <= 1'b0;
    rd(epm_pkg::IDX_SMC, 16'h2000);
    rd(epm_pkg::IDX_EMC, 16'h0000);
    settle();
    check({allow_1000x, allow_100fx}, 2'b00);
    rd(6'h05, 16'h0000);
    wr(epm_pkg::IDX_PAGE, epm_pkg::PAGE_MAIN);
    rd(epm_pkg::IDX_SMC, 16'h0000);
    rd(6'h05, 16'h0000);
    settle();
    check(page1_active, 1'b0);
    rd(6'h30, 16'h0000);
    check(u_mgmt.err, 1'b1);
    final_report();
  end
endmodule // tb
